// ===== hdl/pin_file_cmd_pkg.sv
package pin_file_cmd_pkg;
   // ***********************************************************
   // Register byte offsets
   // ***********************************************************
   localparam logic [7:0] CMD_OFF = 8'h00;
   localparam logic [7:0] GO_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] FILE_CFG_OFF = 8'h0c;
   localparam logic [7:0] DATA0_OFF = 8'h10;
   localparam logic [7:0] DATA1_OFF = 8'h14;
   localparam logic [7:0] DATA2_OFF = 8'h18;
   localparam logic [7:0] DATA3_OFF = 8'h1c;
   localparam logic [7:0] PIN_STATE_OFF = 8'h20;
   localparam logic [7:0] FILE_STATE_OFF = 8'h24;

   // ***********************************************************
   // Table sizes
   // ***********************************************************
   localparam int NUM_PINS = 4;
   localparam int NUM_FILES = 4;

   // ***********************************************************
   // Operation codes in CMD[27:24]
   // ***********************************************************
   localparam logic [3:0] OP_ENABLE = 4'h1;
   localparam logic [3:0] OP_UNBLOCK = 4'h2;
   localparam logic [3:0] OP_DEACT = 4'h3;
   localparam logic [3:0] OP_ACT = 4'h4;
   localparam logic [3:0] OP_SELECT = 4'h5;
   localparam logic [3:0] OP_ACCESS = 4'h6;
   localparam logic [3:0] OP_LOAD_PIN = 4'h7;

   // ***********************************************************
   // Parameter codings and lengths
   // ***********************************************************
   localparam logic [7:0] P_ZERO = 8'h00;
   localparam logic [7:0] P1_PATH_ROOT = 8'h08;
   localparam logic [7:0] P1_PATH_CUR = 8'h09;
   localparam logic [7:0] LC_EMPTY = 8'h00;
   localparam logic [7:0] LC_FID = 8'h02;
   localparam logic [7:0] LC_PIN = 8'h08;
   localparam logic [7:0] LC_UNBLOCK = 8'h10;
   localparam logic [1:0] PIN_TRIES_INIT = 2'h3;
   localparam logic [3:0] UB_TRIES_INIT = 4'ha;
   localparam logic [7:0] REPL_NONE = 8'h00;

   // ***********************************************************
   // Status words
   // ***********************************************************
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [11:0] SW_RETRY_HI = 12'h63c;
   localparam logic [15:0] SW_AUTH_BLOCKED = 16'h6983;
   localparam logic [15:0] SW_SEC_NOT_MET = 16'h6982;
   localparam logic [15:0] SW_COND_NOT_MET = 16'h6985;
   localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
   localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
   localparam logic [15:0] SW_NO_FILE = 16'h6a82;
   localparam logic [15:0] SW_NO_REF = 16'h6a88;
   localparam logic [15:0] SW_BAD_OP = 16'h6d00;
endpackage

// ===== hdl/pin_file_cmd.sv
// Function
// - Refuse enable when enabled or blocked
// - Correct enable PIN: counter three, enabled
// - Wrong enable PIN: decrement, stay disabled
// - Third miss blocks; only unblock or PIN load clears
// - Blocked grants access only when disabled
// - Enabling clears replacement qualifier to zero
// - Enable: P1 zero, Lc eight, no Le
// - Unblock allowed unless unblock key blocked
// - Good key: new PIN, counters reset, satisfied
// - Bad key decrements key counter only
// - Bad key one to nine returns 63CX
// - Tenth bad key blocks, later 6983
// - Empty unblock reports key retry count
// - Unblock: P1 zero, Lc empty or 16
// - Reference byte: bits 6..5 zero, nonzero
// - Deactivate only with access condition met
// - Success sets current file, failure keeps
// - Deactivated file refuses access; select, activate, deactivate work
// - Deactivate P2 zero, P1 selection codes
// - Empty deactivate targets current file
// - Activate only with access condition met
`timescale 1ns/10ps
module pin_file_cmd
   import pin_file_cmd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [3:0] op;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic [127:0] data;
      logic [15:0] sw;
      logic done;
      logic [31:0] rdata;
      logic [NUM_PINS-1:0][63:0] pin_val;
      logic [NUM_PINS-1:0][63:0] ub_val;
      logic [NUM_PINS-1:0][1:0] pin_tries;
      logic [NUM_PINS-1:0][3:0] ub_tries;
      logic [NUM_PINS-1:0] pin_en;
      logic [NUM_PINS-1:0] pin_blk;
      logic [NUM_PINS-1:0] ub_blk;
      logic [NUM_PINS-1:0] pin_sat;
      logic [NUM_PINS-1:0][7:0] repl_q;
      logic [NUM_FILES-1:0][15:0] fid;
      logic [NUM_FILES-1:0] fvalid;
      logic [NUM_FILES-1:0] fdeact;
      logic [NUM_FILES-1:0] ac_deact;
      logic [NUM_FILES-1:0] ac_act;
      logic [1:0] cur_ef;
      logic cur_ef_ok;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic wr_acc;
   logic rd_setup;
   logic go;
   logic ref_ok;
   logic [1:0] pidx;
   logic [4:0] ref_num;
   logic pin_match;
   logic ub_match;
   logic [1:0] tries_dec;
   logic [3:0] ub_dec;
   logic [127:0] shifted;
   logic [15:0] tgt_fid;
   logic sel_ok;
   logic use_cur;
   logic found;
   logic [1:0] fidx;
   logic [31:0] pin_word;

   // ***********************************************************
   // APB handshake
   // ***********************************************************
   // Zero wait states: every access completes in its first access cycle
   assign pready = penable;
   assign pslverr = 1'b0;
   assign prdata = st_reg.rdata;
   assign wr_acc = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign go = wr_acc & (paddr == GO_OFF);

   // ***********************************************************
   // Command decode helpers
   // ***********************************************************
   // Reference number sits in the five low bits; table holds NUM_PINS of them
   assign ref_num = st_reg.p2[4:0];
   assign ref_ok = (st_reg.p2[6:5] == 2'h0) && (ref_num != 5'h00) &&
      (ref_num <= 5'(NUM_PINS));
   assign pidx = 2'(ref_num - 5'h01);
   assign pin_match = (st_reg.data[127:64] == st_reg.pin_val[pidx]);
   assign ub_match = (st_reg.data[127:64] == st_reg.ub_val[pidx]);
   assign tries_dec = st_reg.pin_tries[pidx] - 2'h1;
   assign ub_dec = st_reg.ub_tries[pidx] - 4'h1;
   // Identifier is the last two bytes of the id or path in the data field
   assign shifted = st_reg.data << {st_reg.lc - LC_FID, 3'h0};
   assign tgt_fid = shifted[127:112];
   assign use_cur = (st_reg.p1 == P_ZERO) && (st_reg.lc == LC_EMPTY);

   // Selection code and length check for file commands
   always_comb begin
      sel_ok = 1'b0;
      if (use_cur) begin
         sel_ok = 1'b1;
      end else if (st_reg.p1 == P_ZERO) begin
         sel_ok = (st_reg.lc == LC_FID);
      end else if ((st_reg.p1 == P1_PATH_ROOT) || (st_reg.p1 == P1_PATH_CUR)) begin
         sel_ok = (st_reg.lc >= LC_FID) && (st_reg.lc <= LC_UNBLOCK) && !st_reg.lc[0];
      end
   end

   // Look up the target file slot
   always_comb begin
      found = 1'b0;
      fidx = st_reg.cur_ef;
      if (use_cur) begin
         found = st_reg.cur_ef_ok;
      end else begin
         for (int i = 0; i < NUM_FILES; i++) begin
            if (!found && st_reg.fvalid[i] && (st_reg.fid[i] == tgt_fid)) begin
               found = 1'b1;
               fidx = 2'(i);
            end
         end
      end
   end

   // Blocked and enabled means the condition cannot be met at all
   assign pin_word = {18'h0, st_reg.ub_blk[pidx], st_reg.ub_tries[pidx],
      st_reg.repl_q[pidx][3:0],
      ~st_reg.pin_en[pidx] | (st_reg.pin_sat[pidx] & ~st_reg.pin_blk[pidx]),
      st_reg.pin_blk[pidx], st_reg.pin_en[pidx], st_reg.pin_tries[pidx]};

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      st_next = st_reg;
      // Read data is captured in the setup phase so prdata comes from a flop
      if (rd_setup) begin
         case (paddr)
            CMD_OFF: st_next.rdata = {4'h0, st_reg.op, st_reg.lc, st_reg.p2, st_reg.p1};
            STATUS_OFF: st_next.rdata = {15'h0, st_reg.done, st_reg.sw};
            DATA0_OFF: st_next.rdata = st_reg.data[127:96];
            DATA1_OFF: st_next.rdata = st_reg.data[95:64];
            DATA2_OFF: st_next.rdata = st_reg.data[63:32];
            DATA3_OFF: st_next.rdata = st_reg.data[31:0];
            PIN_STATE_OFF: st_next.rdata = pin_word;
            FILE_STATE_OFF: st_next.rdata = {21'h0, st_reg.cur_ef_ok, st_reg.cur_ef,
               st_reg.fvalid, st_reg.fdeact};
            default: st_next.rdata = 32'h0;
         endcase
      end
      // Register writes
      if (wr_acc) begin
         case (paddr)
            CMD_OFF: begin
               st_next.p1 = pwdata[7:0];
               st_next.p2 = pwdata[15:8];
               st_next.lc = pwdata[23:16];
               st_next.op = pwdata[27:24];
            end
            DATA0_OFF: st_next.data[127:96] = pwdata;
            DATA1_OFF: st_next.data[95:64] = pwdata;
            DATA2_OFF: st_next.data[63:32] = pwdata;
            DATA3_OFF: st_next.data[31:0] = pwdata;
            FILE_CFG_OFF: begin
               st_next.fid[pwdata[17:16]] = pwdata[15:0];
               st_next.ac_deact[pwdata[17:16]] = pwdata[18];
               st_next.ac_act[pwdata[17:16]] = pwdata[19];
               st_next.fvalid[pwdata[17:16]] = pwdata[20];
               st_next.fdeact[pwdata[17:16]] = pwdata[21];
            end
            default: ;
         endcase
      end
      // Command execution, in the access cycle of the GO write
      if (go) begin
         st_next.done = 1'b1;
         st_next.sw = SW_BAD_OP;
         case (st_reg.op)
            OP_ENABLE: begin
               if (st_reg.p1 != P_ZERO) begin
                  st_next.sw = SW_BAD_P1P2;
               end else if (st_reg.lc != LC_PIN) begin
                  st_next.sw = SW_WRONG_LEN;
               end else if (!ref_ok) begin
                  st_next.sw = SW_NO_REF;
               end else if (st_reg.pin_en[pidx] || st_reg.pin_blk[pidx]) begin
                  st_next.sw = SW_COND_NOT_MET;
               end else if (pin_match) begin
                  st_next.pin_tries[pidx] = PIN_TRIES_INIT;
                  st_next.pin_en[pidx] = 1'b1;
                  st_next.repl_q[pidx] = REPL_NONE;
                  st_next.sw = SW_OK;
               end else begin
                  // Blocked PIN is left disabled, so its access stays granted
                  st_next.pin_tries[pidx] = tries_dec;
                  st_next.pin_blk[pidx] = (tries_dec == 2'h0);
                  st_next.sw = {SW_RETRY_HI, 2'h0, tries_dec};
               end
            end
            OP_UNBLOCK: begin
               if (st_reg.p1 != P_ZERO) begin
                  st_next.sw = SW_BAD_P1P2;
               end else if (!ref_ok) begin
                  st_next.sw = SW_NO_REF;
               end else if (st_reg.lc == LC_EMPTY) begin
                  // Query only: count is zero once the key is blocked
                  st_next.sw = {SW_RETRY_HI, st_reg.ub_tries[pidx]};
               end else if (st_reg.lc != LC_UNBLOCK) begin
                  st_next.sw = SW_WRONG_LEN;
               end else if (st_reg.ub_blk[pidx]) begin
                  st_next.sw = SW_AUTH_BLOCKED;
               end else if (ub_match) begin
                  st_next.pin_val[pidx] = st_reg.data[63:0];
                  st_next.ub_tries[pidx] = UB_TRIES_INIT;
                  st_next.pin_tries[pidx] = PIN_TRIES_INIT;
                  st_next.pin_en[pidx] = 1'b1;
                  st_next.pin_blk[pidx] = 1'b0;
                  st_next.pin_sat[pidx] = 1'b1;
                  st_next.sw = SW_OK;
               end else begin
                  st_next.ub_tries[pidx] = ub_dec;
                  st_next.ub_blk[pidx] = (ub_dec == 4'h0);
                  st_next.sw = {SW_RETRY_HI, ub_dec};
               end
            end
            OP_DEACT,
            OP_ACT: begin
               if (st_reg.p2 != P_ZERO) begin
                  st_next.sw = SW_BAD_P1P2;
               end else if (!sel_ok) begin
                  st_next.sw = ((st_reg.p1 == P_ZERO) || (st_reg.p1 == P1_PATH_ROOT) ||
                     (st_reg.p1 == P1_PATH_CUR)) ? SW_WRONG_LEN : SW_BAD_P1P2;
               end else if (!found) begin
                  st_next.sw = SW_NO_FILE;
               end else if (st_reg.op == OP_DEACT) begin
                  if (!st_reg.ac_deact[fidx]) begin
                     st_next.sw = SW_SEC_NOT_MET;
                  end else begin
                     st_next.fdeact[fidx] = 1'b1;
                     st_next.cur_ef = fidx;
                     st_next.cur_ef_ok = 1'b1;
                     st_next.sw = SW_OK;
                  end
               end else begin
                  if (!st_reg.ac_act[fidx]) begin
                     st_next.sw = SW_SEC_NOT_MET;
                  end else begin
                     st_next.fdeact[fidx] = 1'b0;
                     st_next.cur_ef = fidx;
                     st_next.cur_ef_ok = 1'b1;
                     st_next.sw = SW_OK;
                  end
               end
            end
            OP_SELECT: begin
               // Selection still reaches a deactivated file
               if ((st_reg.p1 != P_ZERO) || (st_reg.lc != LC_FID)) begin
                  st_next.sw = SW_BAD_P1P2;
               end else if (!found) begin
                  st_next.sw = SW_NO_FILE;
               end else begin
                  st_next.cur_ef = fidx;
                  st_next.cur_ef_ok = 1'b1;
                  st_next.sw = SW_OK;
               end
            end
            OP_ACCESS: begin
               if (!st_reg.cur_ef_ok) begin
                  st_next.sw = SW_NO_FILE;
               end else if (st_reg.fdeact[st_reg.cur_ef]) begin
                  st_next.sw = SW_COND_NOT_MET;
               end else begin
                  st_next.sw = SW_OK;
               end
            end
            OP_LOAD_PIN: begin
               // Personalisation: PIN and key from data, qualifier from P1
               if (!ref_ok) begin
                  st_next.sw = SW_NO_REF;
               end else begin
                  st_next.pin_val[pidx] = st_reg.data[127:64];
                  st_next.ub_val[pidx] = st_reg.data[63:0];
                  st_next.pin_tries[pidx] = PIN_TRIES_INIT;
                  st_next.ub_tries[pidx] = UB_TRIES_INIT;
                  st_next.pin_en[pidx] = st_reg.lc[0];
                  st_next.pin_blk[pidx] = 1'b0;
                  st_next.ub_blk[pidx] = 1'b0;
                  st_next.pin_sat[pidx] = 1'b0;
                  st_next.repl_q[pidx] = st_reg.p1;
                  st_next.sw = SW_OK;
               end
            end
            default: st_next.sw = SW_BAD_OP;
         endcase
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   // Counters reset to zero; a real card keeps them in memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   AST_ENABLE_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_ENABLE && st_reg.p1 == P_ZERO && st_reg.lc == LC_PIN &&
      ref_ok && (st_reg.pin_en[pidx] || st_reg.pin_blk[pidx]))
      |=> (st_reg.sw == SW_COND_NOT_MET) && $stable(st_reg.pin_tries))
      else $error("enable on enabled or blocked PIN not refused");

   AST_ENABLE_OK: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_ENABLE && st_reg.p1 == P_ZERO && st_reg.lc == LC_PIN &&
      ref_ok && !st_reg.pin_en[pidx] && !st_reg.pin_blk[pidx] && pin_match)
      |=> st_reg.pin_en[$past(pidx)] && st_reg.pin_tries[$past(pidx)] == PIN_TRIES_INIT &&
      st_reg.repl_q[$past(pidx)] == REPL_NONE && st_reg.sw == SW_OK)
      else $error("correct enable did not restore PIN");

   AST_ENABLE_WRONG: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_ENABLE && st_reg.p1 == P_ZERO && st_reg.lc == LC_PIN &&
      ref_ok && !st_reg.pin_en[pidx] && !st_reg.pin_blk[pidx] && !pin_match)
      |=> !st_reg.pin_en[$past(pidx)] &&
      st_reg.pin_tries[$past(pidx)] == $past(st_reg.pin_tries[pidx]) - 2'h1)
      else $error("wrong enable did not decrement");

   AST_PIN_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.pin_blk & ~$past(st_reg.pin_blk)) != '0
      |-> st_reg.pin_tries[$past(pidx)] == 2'h0)
      else $error("PIN blocked with attempts left");

   AST_UNBLOCK_OK: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_UNBLOCK && st_reg.p1 == P_ZERO && st_reg.lc == LC_UNBLOCK &&
      ref_ok && !st_reg.ub_blk[pidx] && ub_match)
      |=> st_reg.ub_tries[$past(pidx)] == UB_TRIES_INIT && !st_reg.pin_blk[$past(pidx)] &&
      st_reg.pin_tries[$past(pidx)] == PIN_TRIES_INIT && st_reg.pin_sat[$past(pidx)])
      else $error("unblock did not restore counters");

   AST_UNBLOCK_WRONG: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_UNBLOCK && st_reg.p1 == P_ZERO && st_reg.lc == LC_UNBLOCK &&
      ref_ok && !st_reg.ub_blk[pidx] && !ub_match)
      |=> st_reg.sw == {SW_RETRY_HI, $past(st_reg.ub_tries[pidx]) - 4'h1} &&
      $stable(st_reg.pin_blk) && $stable(st_reg.pin_tries))
      else $error("wrong unblock key mishandled");

   AST_UNBLOCK_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_UNBLOCK && st_reg.p1 == P_ZERO && st_reg.lc == LC_UNBLOCK &&
      ref_ok && st_reg.ub_blk[pidx])
      |=> st_reg.sw == SW_AUTH_BLOCKED && $stable(st_reg.pin_val))
      else $error("blocked key did not answer 6983");

   AST_FILE_FAIL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      (go && (st_reg.op == OP_DEACT || st_reg.op == OP_ACT))
      ##1 (st_reg.sw != SW_OK) |-> $stable(st_reg.cur_ef) && $stable(st_reg.fdeact))
      else $error("failed file command changed state");

   AST_DEACT_AC: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_reg.op == OP_DEACT && st_reg.p2 == P_ZERO && sel_ok && found)
      |=> st_reg.fdeact[$past(fidx)] == $past(st_reg.ac_deact[fidx]) ||
      $past(st_reg.fdeact[fidx]))
      else $error("deactivation ignored access condition");

endmodule // pin_file_cmd

// ===== test/apdu_terminal.sv
`timescale 1ns/10ps
module apdu_terminal (
   // Clock
   input wire logic pclk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready
);
   // Bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; starts one edge after the call so a release never meets a new setup
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic ok);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      ok = (pready === 1'b1);
      rdata = prdata;
      // Stale address and data are inverted so the slave cannot lean on them
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // apdu_terminal

// ===== test/pin_state_and_file_lifecycle_cmds_bench.sv
`timescale 1ns/10ps
module pin_state_and_file_lifecycle_cmds_bench import pin_file_cmd_pkg::*;;
   localparam logic [63:0] PA = 64'h1122_3344_5566_7788;
   localparam logic [63:0] PB = 64'h0102_0304_0506_0708;
   localparam logic [63:0] PC = 64'h9988_7766_5544_3322;
   localparam logic [63:0] KA = 64'h5a5a_a5a5_0f0f_f0f0;
   localparam logic [63:0] KB = 64'h5a5a_a5a5_0f0f_f0f1;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_total, check_count, i;
   // ***********************************
   // Block and terminal
   // ***********************************
   pin_file_cmd DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   apdu_terminal term (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ***********************************
   // Helpers
   // ***********************************
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A missing pready ends the run at once
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ok;
      term.xfer(w, a, d, q, ok);
      check({31'h0, pslverr}, 32'h0);
      if (ok !== 1'b1) begin
         err_total++;
         final_report;
      end
   endtask
   task automatic dat(input logic [63:0] a, input logic [63:0] b);
      bus(1'b1, DATA0_OFF, a[63:32]);
      bus(1'b1, DATA1_OFF, a[31:0]);
      bus(1'b1, DATA2_OFF, b[63:32]);
      bus(1'b1, DATA3_OFF, b[31:0]);
   endtask
   // Issue a command and compare its status word
   task automatic sw(input logic [3:0] op, input logic [7:0] p1, p2, lc, input logic [15:0] e);
      bus(1'b1, CMD_OFF, {4'h0, op, lc, p2, p1});
      bus(1'b1, GO_OFF, 32'h1);
      bus(1'b0, STATUS_OFF, 32'h0);
      check({16'h0, q[15:0]}, {16'h0, e});
   endtask
   task automatic pin(input logic [7:0] r);
      bus(1'b1, CMD_OFF, {16'h0, r, 8'h00});
      bus(1'b0, PIN_STATE_OFF, 32'h0);
   endtask
   function automatic logic [31:0] ps(input logic ubb, input logic [3:0] ubt, rq,
                                      input logic [2:0] abe, input logic [1:0] tr);
      return {18'h0, ubb, ubt, rq, abe, tr};
   endfunction
   task automatic fst(input logic [1:0] cur, input logic [3:0] dv);
      bus(1'b0, FILE_STATE_OFF, 32'h0);
      check(q, {21'h0, 1'b1, cur, 4'h3, dv});
   endtask
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_enable;
      dat(PA, KA);
      sw(OP_LOAD_PIN, 8'h08, 8'h01, 8'h00, SW_OK);
      dat(PB, KA);
      sw(OP_ENABLE, P_ZERO, 8'h01, LC_PIN, {SW_RETRY_HI, 4'h2});
      pin(8'h01);
      check(q, ps(1'b0, 4'ha, 4'h8, 3'b100, 2'h2));
      dat(PA, KA);
      sw(OP_ENABLE, P_ZERO, 8'h01, LC_PIN, SW_OK);
      pin(8'h01);
      check(q, ps(1'b0, 4'ha, REPL_NONE[3:0], 3'b001, 2'h3));
      sw(OP_ENABLE, P_ZERO, 8'h01, LC_PIN, SW_COND_NOT_MET);
      sw(OP_ENABLE, P_ZERO, 8'h01, LC_UNBLOCK, SW_WRONG_LEN);
      sw(OP_ENABLE, 8'h01, 8'h01, LC_PIN, SW_BAD_P1P2);
      sw(OP_ENABLE, P_ZERO, 8'h41, LC_PIN, SW_NO_REF);
      sw(OP_ENABLE, P_ZERO, 8'h00, LC_PIN, SW_NO_REF);
      sw(OP_UNBLOCK, P_ZERO, 8'h01, LC_PIN, SW_WRONG_LEN);
      pin(8'h01);
      check(q, ps(1'b0, 4'ha, 4'h0, 3'b001, 2'h3));
   endtask
   // Block a PIN, then wear out and block its unblock key
   task automatic t_unblock;
      dat(PA, KA);
      sw(OP_LOAD_PIN, P_ZERO, 8'h82, 8'h00, SW_OK);
      dat(PB, KA);
      for (i = 2; i >= 0; i--) begin
         sw(OP_ENABLE, P_ZERO, 8'h82, LC_PIN, {SW_RETRY_HI, i[3:0]});
      end
      dat(PA, KA);
      sw(OP_ENABLE, P_ZERO, 8'h82, LC_PIN, SW_COND_NOT_MET);
      sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_EMPTY, {SW_RETRY_HI, 4'ha});
      dat(KB, PC);
      for (i = 9; i >= 1; i--) begin
         sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_UNBLOCK, {SW_RETRY_HI, i[3:0]});
      end
      pin(8'h82);
      // Blocked but disabled, so access stays granted
      check(q, ps(1'b0, 4'h1, 4'h0, 3'b110, 2'h0));
      dat(KA, PC);
      sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_UNBLOCK, SW_OK);
      pin(8'h82);
      check(q, ps(1'b0, 4'ha, 4'h0, 3'b101, 2'h3));
      dat(KB, PA);
      for (i = 9; i >= 0; i--) begin
         sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_UNBLOCK, {SW_RETRY_HI, i[3:0]});
      end
      sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_UNBLOCK, SW_AUTH_BLOCKED);
      sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_EMPTY, {SW_RETRY_HI, 4'h0});
      dat(KA, PA);
      sw(OP_UNBLOCK, P_ZERO, 8'h82, LC_UNBLOCK, SW_AUTH_BLOCKED);
      pin(8'h82);
      check(q, ps(1'b1, 4'h0, 4'h0, 3'b101, 2'h3));
   endtask
   // Slot 0 may be deactivated and activated, slot 1 may not
   task automatic t_files;
      bus(1'b1, FILE_CFG_OFF, {10'h0, 4'b0111, 2'd0, 16'h2f01});
      bus(1'b1, FILE_CFG_OFF, {10'h0, 4'b0100, 2'd1, 16'h2f02});
      bus(1'b1, DATA0_OFF, 32'h2f01_0000);
      sw(OP_DEACT, P_ZERO, P_ZERO, LC_FID, SW_OK);
      fst(2'd0, 4'h1);
      bus(1'b1, DATA0_OFF, 32'h2f02_0000);
      sw(OP_DEACT, P_ZERO, P_ZERO, LC_FID, SW_SEC_NOT_MET);
      sw(OP_DEACT, 8'h01, P_ZERO, LC_FID, SW_BAD_P1P2);
      sw(OP_DEACT, P_ZERO, 8'h01, LC_FID, SW_BAD_P1P2);
      sw(OP_DEACT, P_ZERO, P_ZERO, 8'h03, SW_WRONG_LEN);
      fst(2'd0, 4'h1);
      bus(1'b1, DATA0_OFF, 32'h2f01_0000);
      sw(OP_ACCESS, P_ZERO, P_ZERO, LC_FID, SW_COND_NOT_MET);
      bus(1'b1, DATA0_OFF, 32'h3f00_2f01);
      sw(OP_ACT, P1_PATH_ROOT, P_ZERO, 8'h04, SW_OK);
      fst(2'd0, 4'h0);
      sw(OP_DEACT, P_ZERO, P_ZERO, LC_EMPTY, SW_OK);
      fst(2'd0, 4'h1);
      bus(1'b1, DATA0_OFF, 32'h2f01_0000);
      sw(OP_SELECT, P_ZERO, P_ZERO, LC_FID, SW_OK);
      bus(1'b1, DATA0_OFF, 32'h2f02_0000);
      sw(OP_SELECT, P_ZERO, P_ZERO, LC_FID, SW_OK);
      fst(2'd1, 4'h1);
      bus(1'b1, DATA0_OFF, 32'h2f01_0000);
      sw(OP_ACT, P1_PATH_CUR, P_ZERO, LC_FID, SW_OK);
      fst(2'd0, 4'h0);
      bus(1'b0, CMD_OFF, 32'h0);
      check(q, {4'h0, OP_ACT, LC_FID, P_ZERO, P1_PATH_CUR});
      bus(1'b0, DATA0_OFF, 32'h0);
      check(q, 32'h2f01_0000);
      sw(4'h0, P_ZERO, P_ZERO, LC_EMPTY, SW_BAD_OP);
      fst(2'd0, 4'h0);
   endtask
   // Mid-run reset empties every table; no memory survives it in this model
   task automatic t_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, FILE_STATE_OFF, 32'h0);
      check(q, 32'h0);
      pin(8'h82);
      check(q, ps(1'b0, 4'h0, 4'h0, 3'b100, 2'h0));
   endtask
   // ***********************************
   // Main sequence and watchdog
   // ***********************************
   initial begin
      err_total = 0;
      check_count = 0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_enable;
      t_unblock;
      t_files;
      t_reset;
      final_report;
   end
   initial begin
      repeat (90000) @(posedge pclk);
      err_total++;
      final_report;
   end
endmodule // pin_state_and_file_lifecycle_cmds_bench
